// >>> src/os_filter_pkg.sv
// shared constants and types for the oversampling average filter
package os_filter_pkg;

    // ========================================================================
    // geometry
    localparam int CHANNELS   = 8;
    localparam int SAMPLE_W   = 16;
    localparam int MAX_LOG2   = 6;
    localparam int ACC_W      = SAMPLE_W + MAX_LOG2;
    localparam int COUNT_W    = MAX_LOG2 + 1;

    // ========================================================================
    // ratio-select codes
    localparam logic [2:0] RATIO_CODE_NONE    = 3'h0;
    localparam logic [2:0] RATIO_CODE_MAX     = 3'h6;
    localparam logic [2:0] RATIO_CODE_INVALID = 3'h7;

    // ========================================================================
    // timing: one internal sample slot at the unaveraged 500 kSPS rate
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SAMPLE_PERIOD_NS = 2000;
    localparam int SAMPLE_CYCLES    = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W            = $clog2(SAMPLE_CYCLES + 1);

    // ========================================================================
    // carriers
    typedef logic signed [SAMPLE_W-1:0] sample_t;

    typedef struct packed {
        sample_t [CHANNELS-1:0] ch;
    } channel_set_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_GAP,
        ST_EMIT
    } filter_state_e;

endpackage

// >>> src/result_buffer.sv
// two-entry buffer on the result path; all outputs come from flip-flops
module result_buffer
    import os_filter_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // filling side
    input  wire logic         in_valid_i,
    input  channel_set_s      in_data_i,
    output logic              in_ready_o,
    // draining side
    output logic              out_valid_o,
    output channel_set_s      out_data_o,
    input  wire logic         out_ready_i
);

    // ========================================================================
    // storage: head entry feeds the output, tail catches a word during a stall
    channel_set_s tail_reg;
    logic         tail_valid_reg;
    logic         push;
    logic         pop;

    assign push = in_valid_i && !tail_valid_reg;
    assign pop  = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_valid_o    <= 1'b0;
            tail_valid_reg <= 1'b0;
        end else if (pop) begin
            if (tail_valid_reg) begin
                tail_valid_reg <= 1'b0;
            end else if (!push) begin
                out_valid_o <= 1'b0;
            end
        end else if (push) begin
            if (!out_valid_o) begin
                out_valid_o <= 1'b1;
            end else begin
                tail_valid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (pop && tail_valid_reg) begin
            out_data_o <= tail_reg;
        end else if (push && (pop || !out_valid_o)) begin
            out_data_o <= in_data_i;
        end
        if (push && out_valid_o && !pop) begin
            tail_reg <= in_data_i;
        end
    end

    // ready goes low only once both entries hold words
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            in_ready_o <= 1'b1;
        end else begin
            in_ready_o <= !(tail_valid_reg ? !pop : (push && out_valid_o && !pop));
        end
    end

endmodule

// >>> src/oversampling_average_filter.sv
// oversampling averaging filter: burst sequencing, accumulation and decimation
module oversampling_average_filter
    import os_filter_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // pins from the host
    input  wire logic [2:0]   ratio_select_pins_i,
    input  wire logic         convert_start_group_a_i,
    input  wire logic         convert_start_group_b_i,
    // converter core
    output logic              conv_trigger_o,
    input  wire logic         sample_valid_i,
    input  channel_set_s      sample_data_i,
    // averaged results
    output logic              result_valid_o,
    output channel_set_s      result_data_o,
    input  wire logic         result_ready_i,
    // status
    output logic              busy_o
);

    // ========================================================================
    // ratio decoding
    // invalid code is folded onto no averaging so a misconfigured host gets raw data
    function automatic logic [2:0] ratio_log2(input logic [2:0] code);
        if (code == RATIO_CODE_INVALID) begin
            return RATIO_CODE_NONE;
        end
        return code;
    endfunction

    // ========================================================================
    // start pin synchronisers
    logic [2:0] start_a_sync_reg;
    logic [2:0] start_b_sync_reg;
    logic       start_level_reg;
    logic       start_both;
    logic       start_agree;
    logic       start_edge;

    always_ff @(posedge clk_i) begin
        start_a_sync_reg <= {start_a_sync_reg[1:0], convert_start_group_a_i};
        start_b_sync_reg <= {start_b_sync_reg[1:0], convert_start_group_b_i};
    end

    assign start_agree = (start_a_sync_reg[1] == start_a_sync_reg[2])
                      && (start_b_sync_reg[1] == start_b_sync_reg[2]);
    assign start_both  = start_a_sync_reg[2] && start_b_sync_reg[2];
    assign start_edge  = start_agree && start_both && !start_level_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            start_level_reg <= 1'b1;
        end else if (start_agree) begin
            start_level_reg <= start_both;
        end
    end

    // ratio pins pass the same three-stage chain; a code counts once stages two and three agree,
    // so a pin caught mid-change can never be latched as a half-old, half-new ratio
    logic [2:0] ratio_sync0_reg;
    logic [2:0] ratio_sync1_reg;
    logic [2:0] ratio_sync2_reg;
    logic [2:0] ratio_level_reg;

    always_ff @(posedge clk_i) begin
        ratio_sync0_reg <= ratio_select_pins_i;
        ratio_sync1_reg <= ratio_sync0_reg;
        ratio_sync2_reg <= ratio_sync1_reg;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ratio_level_reg <= RATIO_CODE_NONE;
        end else if (ratio_sync1_reg == ratio_sync2_reg) begin
            ratio_level_reg <= ratio_sync2_reg;
        end
    end

    // ========================================================================
    // burst sequencer
    filter_state_e      state_reg;
    logic [2:0]         shift_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] ratio_count;
    logic [GAP_W-1:0]   gap_reg;
    logic               last_sample;
    logic               buf_ready;
    logic               push;
    channel_set_s       avg_data;

    assign ratio_count = COUNT_W'(1) << shift_reg;
    assign last_sample = (count_reg + COUNT_W'(1)) == ratio_count;
    assign push        = (state_reg == ST_EMIT) && buf_ready;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_edge) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (sample_valid_i) begin
                        state_reg <= last_sample ? ST_EMIT : ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (gap_reg == GAP_W'(0)) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_EMIT: begin
                    if (buf_ready) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // the ratio is caught once per burst; pin changes mid-burst wait for the next one
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            shift_reg <= RATIO_CODE_NONE;
        end else if (state_reg == ST_IDLE && start_edge) begin
            shift_reg <= ratio_log2(ratio_level_reg);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_reg <= '0;
        end else if (state_reg == ST_IDLE) begin
            count_reg <= '0;
        end else if (state_reg == ST_CONVERT && sample_valid_i) begin
            count_reg <= count_reg + COUNT_W'(1);
        end
    end

    // internal sampling control paces later samples at one slot each
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gap_reg <= '0;
        end else if (state_reg == ST_CONVERT) begin
            gap_reg <= GAP_W'(SAMPLE_CYCLES - 2);
        end else if (gap_reg != GAP_W'(0)) begin
            gap_reg <= gap_reg - GAP_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_trigger_o <= 1'b0;
        end else begin
            conv_trigger_o <= (state_reg == ST_IDLE && start_edge)
                           || (state_reg == ST_GAP && gap_reg == GAP_W'(0));
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_reg != ST_IDLE) || start_edge;
        end
    end

    // ========================================================================
    // per-channel accumulators
    logic signed [ACC_W-1:0] acc_reg [CHANNELS];

    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
            always_ff @(posedge clk_i) begin
                if (state_reg == ST_IDLE) begin
                    acc_reg[c] <= '0;
                end else if (state_reg == ST_CONVERT && sample_valid_i) begin
                    acc_reg[c] <= acc_reg[c] + ACC_W'(sample_data_i.ch[c]);
                end
            end
            // worst case 64 full-scale samples fits the widened sum, so no saturation
            assign avg_data.ch[c] = SAMPLE_W'(acc_reg[c] >>> shift_reg);
        end
    endgenerate

    // ========================================================================
    // output buffer: a stalled reader holds the sequencer in emit
    result_buffer u_result_buffer (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (state_reg == ST_EMIT),
        .in_data_i   (avg_data),
        .in_ready_o  (buf_ready),
        .out_valid_o (result_valid_o),
        .out_data_o  (result_data_o),
        .out_ready_i (result_ready_i)
    );

    // ========================================================================
    // assertions
    localparam int GAP_BOUND = 256;

    property p_first_on_edge;
        @(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_IDLE && start_edge) |=> conv_trigger_o ##1 (state_reg == ST_CONVERT);
    endproperty
    a_first_on_edge: assert property (p_first_on_edge) else $error("no trigger on start edge");

    property p_internal_retrigger;
        @(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_CONVERT && sample_valid_i && !last_sample)
            |-> ##[1:GAP_BOUND] conv_trigger_o;
    endproperty
    a_internal_retrigger: assert property (p_internal_retrigger) else $error("burst not continued");

    property p_ratio_decode;
        @(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_IDLE && start_edge)
            |=> (shift_reg == (($past(ratio_level_reg) == RATIO_CODE_INVALID) ? RATIO_CODE_NONE
                                                                               : $past(ratio_level_reg)));
    endproperty
    a_ratio_decode: assert property (p_ratio_decode) else $error("ratio decode wrong");

    property p_one_word_per_burst;
        @(posedge clk_i) disable iff (srst_i)
        push |=> (state_reg == ST_IDLE) && !conv_trigger_o;
    endproperty
    a_one_word_per_burst: assert property (p_one_word_per_burst) else $error("extra word in burst");

    property p_sample_count;
        @(posedge clk_i) disable iff (srst_i)
        push |-> (count_reg == ratio_count) && (shift_reg <= RATIO_CODE_MAX);
    endproperty
    a_sample_count: assert property (p_sample_count) else $error("sample count mismatch");

    property p_raw_passthrough;
        @(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_CONVERT && sample_valid_i && shift_reg == RATIO_CODE_NONE)
            |=> (avg_data.ch[0] == $past(sample_data_i.ch[0]));
    endproperty
    a_raw_passthrough: assert property (p_raw_passthrough) else $error("signed result altered");

endmodule

// >>> verif/core_sample_model.sv
// converter core model: answers each sample request after a set latency
module core_sample_model
    import os_filter_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // request from the filter, answer to it
    input  wire logic       trigger_i,
    input  wire logic [7:0] latency_i,
    output logic            valid_o,
    output channel_set_s    data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       pending_reg;
    logic [7:0] wait_reg;
    int         index_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pending_reg <= 1'b0;
            wait_reg    <= 8'h00;
            index_reg   <= 0;
            valid_o     <= 1'b0;
            data_o      <= '0;
        end else begin
            valid_o <= 1'b0;
            // idle cycles invert every bit once per cycle, so a read outside valid is caught
            data_o  <= ~data_o;
            if (trigger_i) begin
                pending_reg <= 1'b1;
                wait_reg    <= latency_i;
            end else if (pending_reg && wait_reg > 8'h01) begin
                wait_reg <= wait_reg - 8'h01;
            end else if (pending_reg) begin
                pending_reg <= 1'b0;
                valid_o     <= 1'b1;
                index_reg   <= index_reg + 1;
                for (int c = 0; c < CHANNELS; c++) begin
                    data_o.ch[c] <= sample_t'(c * 32'h1234 + index_reg * 32'h0F0F + 32'hA001);
                end
            end
        end
    end
endmodule

// >>> verif/tb_oversampling_average_filter.sv
// self-checking bench for the oversampling average filter
module tb_oversampling_average_filter import os_filter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         srst;
    logic [2:0]   ratio_pins;
    logic         start_a;
    logic         start_b;
    logic         trig;
    logic         s_valid;
    channel_set_s s_data;
    logic         r_valid;
    channel_set_s r_data;
    logic         r_ready;
    logic         busy;
    logic [7:0]   latency;
    int           miscompares = 0;
    int           num_checks = 0;
    int           trig_count = 0;
    int           next_index = 0;
    channel_set_s words[$];

    oversampling_average_filter dut_u (.clk_i(clk), .srst_i(srst), .ratio_select_pins_i(ratio_pins),
        .convert_start_group_a_i(start_a), .convert_start_group_b_i(start_b), .conv_trigger_o(trig),
        .sample_valid_i(s_valid), .sample_data_i(s_data), .result_valid_o(r_valid),
        .result_data_o(r_data), .result_ready_i(r_ready), .busy_o(busy));
    core_sample_model core_u (.clk_i(clk), .srst_i(srst), .trigger_i(trig), .latency_i(latency),
        .valid_o(s_valid), .data_o(s_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (!srst && trig === 1'b1) trig_count++;
        if (!srst && r_valid === 1'b1 && r_ready === 1'b1) words.push_back(r_data);
    end

    // ========================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // host paces starts: next one only once the filter is idle
    task automatic wait_done(input int n);
        for (int i = 0; i < 20000 && (busy !== 1'b0 || words.size() < n); i++) @(posedge clk);
        if (busy !== 1'b0 || words.size() < n) begin
            miscompares++;
            $display("[ERR] completion wait expected %0d words seen %0d", n, words.size());
            end_of_test();
        end
    endtask

    // pins low long enough for the synchroniser, then high together or A alone
    task automatic start_burst(input logic [2:0] code, input logic both);
        @(posedge clk);
        ratio_pins <= code;
        start_a <= 1'b0;
        start_b <= 1'b0;
        repeat (4) @(posedge clk);
        start_a <= 1'b1;
        start_b <= both;
        repeat (6) @(posedge clk);
        start_a <= 1'b0;
        start_b <= 1'b0;
    endtask

    function automatic channel_set_s average_of(input logic [2:0] code, input int first);
        channel_set_s w;
        int sum;
        int shift;
        shift = (code == 3'h7) ? 0 : int'(code);
        for (int c = 0; c < CHANNELS; c++) begin
            sum = 0;
            for (int n = first; n < first + (1 << shift); n++) begin
                sum += int'(sample_t'(c * 32'h1234 + n * 32'h0F0F + 32'hA001));
            end
            w.ch[c] = sample_t'(sum >>> shift);
        end
        return w;
    endfunction

    // ========================================
    // scenarios
    task automatic run_ratio(input logic [2:0] code, input logic [7:0] lat);
        int t0;
        int k;
        t0 = trig_count;
        k = (code == 3'h7) ? 1 : (1 << code);
        latency <= lat;
        start_burst(code, 1'b1);
        wait_done(1);
        check("trigger count", 128'(k), 128'(trig_count - t0));
        check("result word", average_of(code, next_index), words.pop_front());
        next_index += k;
        $display("test ratio code %0d done", code);
    endtask

    task automatic test_one_pin();
        int t0;
        t0 = trig_count;
        start_burst(3'h0, 1'b0);
        repeat (20) @(posedge clk);
        check("one pin busy", 128'(0), 128'(busy));
        check("one pin triggers", 128'(0), 128'(trig_count - t0));
        $display("test one pin done");
    endtask

    task automatic test_refuse();
        int t0;
        t0 = trig_count;
        latency <= 8'h20;
        start_burst(3'h1, 1'b1);
        start_burst(3'h1, 1'b1);
        wait_done(1);
        repeat (300) @(posedge clk);
        check("busy start triggers", 128'(2), 128'(trig_count - t0));
        check("busy start words", 128'(1), 128'(words.size()));
        check("busy start result", average_of(3'h1, next_index), words.pop_front());
        next_index += 2;
        $display("test busy start done");
    endtask

    // reader stalls: two words fill the buffer, the third burst must wait
    task automatic test_stall();
        r_ready <= 1'b0;
        latency <= 8'h01;
        for (int i = 0; i < 2; i++) begin
            start_burst(3'h0, 1'b1);
            wait_done(0);
        end
        start_burst(3'h0, 1'b1);
        repeat (50) @(posedge clk);
        check("stall busy", 128'(1), 128'(busy));
        r_ready <= 1'b1;
        wait_done(3);
        for (int i = 0; i < 3; i++) begin
            check("stall word", average_of(3'h0, next_index + i), words.pop_front());
        end
        next_index += 3;
        $display("test stall done");
    endtask

    initial begin
        srst <= 1'b1;
        ratio_pins <= 3'h0;
        start_a <= 1'b0;
        start_b <= 1'b0;
        r_ready <= 1'b1;
        latency <= 8'h01;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int code = 0; code < 8; code++) begin
            run_ratio(3'(code), code[0] ? 8'h25 : 8'h01);
        end
        test_one_pin();
        test_refuse();
        test_stall();
        end_of_test();
    end
endmodule
